// ---- src/tcw_pkg.sv ----
// Shared constants and carrier types of the 8-bit compare waveform timer
package tcw_pkg;
    localparam int          CNT_W      = 8;
    localparam logic [7:0]  CNT_MAX    = 8'hFF;
    localparam logic [7:0]  CNT_BOTTOM = 8'h00;
    localparam logic [7:0]  CNT_RST    = 8'h00;
    localparam logic [7:0]  CMP_RST    = 8'h00;
    localparam logic        OC_RST     = 1'b0;
    // Waveform generation modes
    localparam logic [1:0]  WGM_NORMAL = 2'h0;
    localparam logic [1:0]  WGM_PHASE  = 2'h1;
    localparam logic [1:0]  WGM_CLR    = 2'h2;
    localparam logic [1:0]  WGM_FAST   = 2'h3;
    // Compare output modes
    localparam logic [1:0]  COM_OFF    = 2'h0;
    localparam logic [1:0]  COM_TOGGLE = 2'h1;
    localparam logic [1:0]  COM_CLEAR  = 2'h2;
    localparam logic [1:0]  COM_SET    = 2'h3;

    typedef struct packed {
        logic [1:0] waveform_gen_mode;
        logic [1:0] compare_output_mode;
    } tcw_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tcw_wr_t;

    typedef struct packed {
        logic [7:0] counter_value;
        logic [7:0] compare_value;
        logic [7:0] compare_buffer;
        logic       compare_output_bit;
        logic       overflow_flag;
        logic       compare_flag;
        logic       match_blocked;
        logic       pin_o;
        logic       pin_oe;
    } tcw_state_t;
endpackage

// ---- src/tcw_timer.sv ----
// Compare match output unit and counter of the 8-bit waveform timer
module tcw_timer (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Prescaled timer clock enable
    input  wire logic              timer_tick,
    // Control fields
    input  wire tcw_pkg::tcw_ctrl_t ctrl,
    input  wire logic              force_compare_strobe,
    input  wire tcw_pkg::tcw_wr_t  counter_wr,
    input  wire tcw_pkg::tcw_wr_t  compare_wr,
    input  wire logic              overflow_clr,
    input  wire logic              compare_clr,
    // Port pin
    input  wire logic              port_out_bit,
    input  wire logic              pin_direction_bit,
    output logic                   pin_o,
    output logic                   pin_oe,
    // Status
    output logic [7:0]             counter_value,
    output logic [7:0]             compare_value,
    output logic                   compare_output_bit,
    output logic                   overflow_flag,
    output logic                   compare_flag
);

    tcw_pkg::tcw_state_t s_q;
    tcw_pkg::tcw_state_t s_d;

    logic [1:0] wgm;
    logic [1:0] com;
    logic       fast_pwm;
    logic       at_max;
    logic       match;

    // Match action on the compare bit, used in normal, clear-on-match and fast PWM modes and by forced compare
    function automatic logic match_action(input logic [1:0] mode,
                                          input logic       oc);
        case (mode)
            tcw_pkg::COM_TOGGLE: match_action = ~oc;
            tcw_pkg::COM_CLEAR:  match_action = 1'b0;
            tcw_pkg::COM_SET:    match_action = 1'b1;
            default:             match_action = oc;
        endcase
    endfunction

    assign wgm      = ctrl.waveform_gen_mode;
    assign com      = ctrl.compare_output_mode;
    assign fast_pwm = (wgm == tcw_pkg::WGM_FAST);
    assign at_max   = (s_q.counter_value == tcw_pkg::CNT_MAX);
    // A counter write blanks the comparator for one timer clock
    assign match    = (s_q.counter_value == s_q.compare_value) &&
                      !s_q.match_blocked;

    always_comb begin
        s_d = s_q;
        // Compare value writes: buffered in fast PWM, direct otherwise
        if (compare_wr.valid) begin
            s_d.compare_buffer = compare_wr.data;
            if (!fast_pwm) begin
                s_d.compare_value = compare_wr.data;
            end
        end
        if (timer_tick) begin
            s_d.match_blocked = 1'b0;
            if (match) begin
                s_d.compare_flag = 1'b1;
            end
            case (wgm)
                tcw_pkg::WGM_NORMAL: begin
                    s_d.counter_value = s_q.counter_value + 8'h01;
                    if (at_max) begin
                        s_d.overflow_flag = 1'b1;
                    end
                    if (match) begin
                        s_d.compare_output_bit =
                            match_action(com, s_q.compare_output_bit);
                    end
                end
                tcw_pkg::WGM_CLR: begin
                    if (match) begin
                        s_d.counter_value = tcw_pkg::CNT_BOTTOM;
                        s_d.compare_output_bit =
                            match_action(com, s_q.compare_output_bit);
                    end else begin
                        s_d.counter_value = s_q.counter_value + 8'h01;
                    end
                    if (at_max) begin
                        s_d.overflow_flag = 1'b1;
                    end
                end
                tcw_pkg::WGM_FAST: begin
                    // Wraps every 256 ticks; bottom action beats match
                    s_d.counter_value = s_q.counter_value + 8'h01;
                    if (match) begin
                        s_d.compare_output_bit =
                            match_action(com, s_q.compare_output_bit);
                    end
                    if (at_max) begin
                        s_d.overflow_flag = 1'b1;
                        s_d.compare_value = s_q.compare_buffer;
                        if (com == tcw_pkg::COM_CLEAR) begin
                            s_d.compare_output_bit = 1'b1;
                        end else if (com == tcw_pkg::COM_SET) begin
                            s_d.compare_output_bit = 1'b0;
                        end
                    end
                end
                default: begin
                    // Phase correct mode is not built here; count holds
                    s_d.counter_value = s_q.counter_value;
                end
            endcase
        end
        // Forced compare: bit only, no flag, no counter effect
        if (force_compare_strobe && !fast_pwm &&
            (wgm != tcw_pkg::WGM_PHASE)) begin
            s_d.compare_output_bit =
                match_action(com, s_q.compare_output_bit);
        end
        // Software counter write overrides counting
        if (counter_wr.valid) begin
            s_d.counter_value = counter_wr.data;
            s_d.match_blocked = 1'b1;
        end
        // Hardware set wins over a same-cycle clear
        if (overflow_clr && !(timer_tick && s_d.overflow_flag &&
                              !s_q.overflow_flag)) begin
            s_d.overflow_flag = 1'b0;
        end
        if (overflow_clr && timer_tick && at_max &&
            (wgm != tcw_pkg::WGM_PHASE)) begin
            s_d.overflow_flag = 1'b1;
        end
        if (compare_clr && !(timer_tick && match)) begin
            s_d.compare_flag = 1'b0;
        end
        // Port override decided by output mode alone
        s_d.pin_o  = (com != tcw_pkg::COM_OFF) ?
                     s_d.compare_output_bit : port_out_bit;
        s_d.pin_oe = pin_direction_bit;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q.counter_value      <= tcw_pkg::CNT_RST;
            s_q.compare_value      <= tcw_pkg::CMP_RST;
            s_q.compare_buffer     <= tcw_pkg::CMP_RST;
            s_q.compare_output_bit <= tcw_pkg::OC_RST;
            s_q.overflow_flag      <= 1'b0;
            s_q.compare_flag       <= 1'b0;
            s_q.match_blocked      <= 1'b0;
            s_q.pin_o              <= 1'b0;
            s_q.pin_oe             <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_o              = s_q.pin_o;
    assign pin_oe             = s_q.pin_oe;
    assign counter_value      = s_q.counter_value;
    assign compare_value      = s_q.compare_value;
    assign compare_output_bit = s_q.compare_output_bit;
    assign overflow_flag      = s_q.overflow_flag;
    assign compare_flag       = s_q.compare_flag;

    property p_pin_override;
        @(posedge clk) disable iff (!nrst)
        (ctrl.compare_output_mode != tcw_pkg::COM_OFF)
            |=> (pin_o == compare_output_bit);
    endproperty
    a_pin_override: assert property (p_pin_override)
        else $error("pin does not follow compare bit");

    property p_pin_dir;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (pin_oe == $past(pin_direction_bit));
    endproperty
    a_pin_dir: assert property (p_pin_dir)
        else $error("pin enable does not follow direction bit");

    property p_com_off_holds;
        @(posedge clk) disable iff (!nrst)
        (com == tcw_pkg::COM_OFF) |=>
            (compare_output_bit == $past(compare_output_bit));
    endproperty
    a_com_off_holds: assert property (p_com_off_holds)
        else $error("compare bit changed with output mode off");

    property p_normal_wrap;
        @(posedge clk) disable iff (!nrst)
        (timer_tick && !counter_wr.valid && wgm == tcw_pkg::WGM_NORMAL
         && at_max) |=> (counter_value == 8'h00) && overflow_flag;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap)
        else $error("normal mode wrap or overflow missing");

    property p_clr_match_clear;
        @(posedge clk) disable iff (!nrst)
        (timer_tick && !counter_wr.valid && wgm == tcw_pkg::WGM_CLR
         && match) |=> (counter_value == 8'h00) && compare_flag;
    endproperty
    a_clr_match_clear: assert property (p_clr_match_clear)
        else $error("clear-on-match did not clear counter");

    property p_write_blocks;
        @(posedge clk) disable iff (!nrst)
        (counter_wr.valid && !compare_clr) ##1
            (timer_tick && !compare_flag && !compare_clr)
            |=> !compare_flag;
    endproperty
    a_write_blocks: assert property (p_write_blocks)
        else $error("match not blocked after counter write");

    property p_no_tick_hold;
        @(posedge clk) disable iff (!nrst)
        (!timer_tick && !counter_wr.valid)
            |=> $stable(counter_value);
    endproperty
    a_no_tick_hold: assert property (p_no_tick_hold)
        else $error("counter moved without timer tick");

    property p_fast_bottom;
        @(posedge clk) disable iff (!nrst)
        (timer_tick && fast_pwm && at_max && com == tcw_pkg::COM_CLEAR
         && !force_compare_strobe) |=> compare_output_bit;
    endproperty
    a_fast_bottom: assert property (p_fast_bottom)
        else $error("fast PWM bottom did not set output");

    property p_buffered;
        @(posedge clk) disable iff (!nrst)
        (fast_pwm && !(timer_tick && at_max)) |=> $stable(compare_value);
    endproperty
    a_buffered: assert property (p_buffered)
        else $error("compare value changed outside top in PWM");

    property p_force_no_flag;
        @(posedge clk) disable iff (!nrst)
        (force_compare_strobe && !timer_tick && !compare_flag)
            |=> !compare_flag;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("forced compare set the compare flag");

endmodule

// ---- testbench/tcw_pin_model.sv ----
// Port pin model: resolves the pad level from the timer's pin drive
module tcw_pin_model (
    // Clock
    input  wire logic clk,
    // Pin drive from the timer
    input  wire logic pin_o,
    input  wire logic pin_oe,
    // Resolved pad level
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'b0;
    always @(posedge clk) begin
        if (pin_oe) begin
            last_q <= pin_o;
        end
    end
    // No pull on this pad: an undriven pin shows the inverse of its last value
    assign pin_level = pin_oe ? pin_o : ~last_q;
endmodule

// ---- testbench/timer8_compare_waveform_gen_tb_top.sv ----
// Self-checking testbench of the 8-bit compare waveform timer
module timer8_compare_waveform_gen_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    logic               timer_tick = 1'b0;
    logic               force_compare_strobe = 1'b0;
    logic               overflow_clr = 1'b0;
    logic               compare_clr = 1'b0;
    logic               port_out_bit = 1'b1;
    logic               pin_direction_bit = 1'b0;
    tcw_pkg::tcw_ctrl_t ctrl = '0;
    tcw_pkg::tcw_wr_t   counter_wr = '0;
    tcw_pkg::tcw_wr_t   compare_wr = '0;
    logic               pin_o;
    logic               pin_oe;
    logic               pin_level;
    logic [7:0]         counter_value;
    logic [7:0]         compare_value;
    logic               compare_output_bit;
    logic               overflow_flag;
    logic               compare_flag;
    logic               oc0;
    int                 miscompares = 0;
    int                 comparisons = 0;

    tcw_timer uut (.clk(clk), .nrst(nrst), .timer_tick(timer_tick),
        .ctrl(ctrl), .force_compare_strobe(force_compare_strobe),
        .counter_wr(counter_wr), .compare_wr(compare_wr),
        .overflow_clr(overflow_clr), .compare_clr(compare_clr),
        .port_out_bit(port_out_bit), .pin_direction_bit(pin_direction_bit),
        .pin_o(pin_o), .pin_oe(pin_oe), .counter_value(counter_value),
        .compare_value(compare_value),
        .compare_output_bit(compare_output_bit),
        .overflow_flag(overflow_flag), .compare_flag(compare_flag));
    tcw_pin_model pad (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_level(pin_level));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk);
            timer_tick = 1'b1;
            @(negedge clk);
            timer_tick = 1'b0;
        end
    endtask

    task automatic wr_cnt(input logic [7:0] d);
        @(negedge clk);
        counter_wr = '{1'b1, d};
        @(negedge clk);
        counter_wr.valid = 1'b0;
    endtask

    task automatic wr_cmp(input logic [7:0] d);
        @(negedge clk);
        compare_wr = '{1'b1, d};
        @(negedge clk);
        compare_wr.valid = 1'b0;
    endtask

    // One-cycle strobes: force, overflow clear, compare flag clear
    task automatic pulses(input logic f, input logic oc, input logic cc);
        @(negedge clk);
        {force_compare_strobe, overflow_clr, compare_clr} = {f, oc, cc};
        @(negedge clk);
        {force_compare_strobe, overflow_clr, compare_clr} = 3'h0;
    endtask

    task automatic test_normal();
        wr_cnt(8'hFF);
        check("counter after write", counter_value, 8'hFF);
        tick(1);
        check("counter wrap", counter_value, 8'h00);
        check("overflow at zero", overflow_flag, 8'h01);
        tick(1);
        check("overflow kept", overflow_flag, 8'h01);
        pulses(1'b0, 1'b1, 1'b0);
        check("overflow cleared", overflow_flag, 8'h00);
        $display("test normal done");
    endtask

    task automatic test_clr_match();
        // Flag left set by the normal mode test
        pulses(1'b0, 1'b0, 1'b1);
        ctrl = '{tcw_pkg::WGM_CLR, tcw_pkg::COM_TOGGLE};
        wr_cmp(8'h02);
        wr_cnt(8'h00);
        oc0 = compare_output_bit;
        tick(2);
        check("clr count", counter_value, 8'h02);
        check("clr flag early", compare_flag, 8'h00);
        tick(1);
        check("clr clear", counter_value, 8'h00);
        check("clr flag", compare_flag, 8'h01);
        check("clr toggle", compare_output_bit, {7'h0, ~oc0});
        // Count above the top value must wrap before the next match
        wr_cnt(8'hFE);
        tick(2);
        check("clr wrap", counter_value, 8'h00);
        check("clr overflow", overflow_flag, 8'h01);
        pulses(1'b0, 1'b1, 1'b0);
        $display("test clear-on-match done");
    endtask

    task automatic test_block();
        pulses(1'b0, 1'b0, 1'b1);
        wr_cmp(8'h05);
        check("direct compare", compare_value, 8'h05);
        // Tick right behind the write so the blanking is exercised
        @(negedge clk);
        counter_wr = '{1'b1, 8'h05};
        @(negedge clk);
        counter_wr.valid = 1'b0;
        timer_tick = 1'b1;
        @(negedge clk);
        timer_tick = 1'b0;
        check("blocked no clear", counter_value, 8'h06);
        check("blocked no flag", compare_flag, 8'h00);
        $display("test block done");
    endtask

    task automatic test_force();
        ctrl = '{tcw_pkg::WGM_NORMAL, tcw_pkg::COM_CLEAR};
        pulses(1'b1, 1'b0, 1'b0);
        check("force clear", compare_output_bit, 8'h00);
        ctrl.compare_output_mode = tcw_pkg::COM_SET;
        pulses(1'b1, 1'b0, 1'b0);
        check("force set", compare_output_bit, 8'h01);
        check("force no flag", compare_flag, 8'h00);
        check("force no count", counter_value, 8'h06);
        check("pin released", pin_oe, 8'h00);
        pin_direction_bit = 1'b1;
        @(negedge clk);
        check("pin driven", pin_oe, 8'h01);
        check("pin shows preset", pin_level, 8'h01);
        port_out_bit = 1'b0;
        ctrl.compare_output_mode = tcw_pkg::COM_OFF;
        @(negedge clk);
        check("pin port value", pin_o, 8'h00);
        check("compare bit kept", compare_output_bit, 8'h01);
        $display("test force done");
    endtask

    task automatic test_fast();
        ctrl = '{tcw_pkg::WGM_NORMAL, tcw_pkg::COM_OFF};
        wr_cmp(8'h03);
        wr_cnt(8'hFE);
        ctrl = '{tcw_pkg::WGM_FAST, tcw_pkg::COM_CLEAR};
        tick(2);
        check("pwm bottom", counter_value, 8'h00);
        check("pwm overflow", overflow_flag, 8'h01);
        check("pwm set at bottom", compare_output_bit, 8'h01);
        check("pin follows bit", pin_o, 8'h01);
        tick(4);
        check("pwm count", counter_value, 8'h04);
        check("pwm clear at match", compare_output_bit, 8'h00);
        wr_cmp(8'h09);
        check("pwm buffered", compare_value, 8'h03);
        ctrl.compare_output_mode = tcw_pkg::COM_SET;
        wr_cnt(8'hFE);
        tick(2);
        check("pwm buffer loaded", compare_value, 8'h09);
        check("inverted clear at bottom", compare_output_bit, 8'h00);
        tick(10);
        check("inverted set at match", compare_output_bit, 8'h01);
        check("pin follows inverted", pin_o, 8'h01);
        $display("test fast pwm done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run is under a hundred cycles; this span leaves wide margin
    initial begin
        #50000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        check("reset counter", counter_value, 8'h00);
        check("reset pin enable", pin_oe, 8'h00);
        test_normal();
        test_clr_match();
        test_block();
        test_force();
        test_fast();
        give_verdict();
    end
endmodule
